// >>> pkg/dmahf_map.svh
// Register map, field positions, reset values and sizes of the
// mid-point flag block.
// Assumes inclusion by bare name from package and design files.
`ifndef DMAHF_MAP_SVH
`define DMAHF_MAP_SVH

// ==========================================================
// Sizes
`define DMAHF_NUM_CHAN 7
`define DMAHF_XFER_W 16
`define DMAHF_ADR_W 8
`define DMAHF_DAT_W 32

// ==========================================================
// Special-function page and byte offsets
`define DMAHF_FLAG_PAGE 4'hf
`define DMAHF_OFF_PAGE 8'h84
`define DMAHF_OFF_FLAGS 8'h88
`define DMAHF_OFF_CONFIG 8'h8c
`define DMAHF_OFF_BITOP 8'h90

// ==========================================================
// Field positions
`define DMAHF_FLAG_RSVD_BIT 7
`define DMAHF_CFG_SEL_LSB 0
`define DMAHF_CFG_SEL_MSB 2
`define DMAHF_CFG_EN_BIT 3
`define DMAHF_CFG_ENALL_LSB 8
`define DMAHF_BITOP_IDX_LSB 0
`define DMAHF_BITOP_IDX_MSB 2
`define DMAHF_BITOP_VAL_BIT 3
`define DMAHF_PAGE_LSB 0
`define DMAHF_PAGE_MSB 3

// ==========================================================
// Reset values
`define DMAHF_RST_FLAGS 7'h00
`define DMAHF_RST_ENABLE 7'h00
`define DMAHF_RST_SELECT 3'h0
`define DMAHF_RST_PAGE 4'h0

`endif

// >>> pkg/dmahf_pkg.sv
// Types shared by the mid-point flag block.
// Assumes dmahf_map.svh on the include path.
`include "dmahf_map.svh"
`default_nettype none

package dmahf_pkg;

  // ==========================================================
  // Bus request as seen by the register slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [`DMAHF_ADR_W-1:0] adr;
    logic [`DMAHF_DAT_W-1:0] dat;
  } dmahf_wb_req_t;

  // ==========================================================
  // Decoded access strobes, one cycle wide
  typedef struct packed {
    logic wr_page;
    logic wr_flags;
    logic wr_config;
    logic wr_bitop;
    logic [`DMAHF_DAT_W-1:0] wdat;
  } dmahf_wr_t;

  typedef logic [`DMAHF_NUM_CHAN-1:0] dmahf_chan_vec_t;

endpackage : dmahf_pkg

`default_nettype wire

// >>> rtl/dmahf_half_detect.sv
// One channel's mid-point detector.
// Assumes offset and size come synchronous to mclk_in from the DMA engine.
`include "dmahf_map.svh"
`default_nettype none

module dmahf_half_detect (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Channel progress
  input wire logic [`DMAHF_XFER_W-1:0] chan_transfer_offset_in,
  input wire logic [`DMAHF_XFER_W-1:0] chan_transfer_size_in,
  // One-cycle hit
  output logic hit_out
);

  logic [`DMAHF_XFER_W-1:0] target;
  logic match;
  logic match_ff;

  // Half, rounded up for odd sizes
  assign target = {1'b0, chan_transfer_size_in[`DMAHF_XFER_W-1:1]}
                  + {{(`DMAHF_XFER_W-1){1'b0}}, chan_transfer_size_in[0]}; // see [RL2] [RL3]
  // Zero size has no mid-point
  assign match = (chan_transfer_offset_in == target)
                 && (chan_transfer_size_in != '0);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= match;
    end
  end

  // Only the moment of reaching the mid-point counts
  assign hit_out = match & ~match_ff; // see [RL2] [RL3]

endmodule : dmahf_half_detect

`default_nettype wire

// >>> rtl/dmahf_wb_slave.sv
// Classic Wishbone slave front end: decode, ack, write strobes.
// Assumes a single-cycle classic master holding its request until ack.
`include "dmahf_map.svh"
`default_nettype none

module dmahf_wb_slave (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Bus request
  input wire dmahf_pkg::dmahf_wb_req_t req_in,
  input wire logic flag_page_ok_in,
  // Decoded strobes
  output dmahf_pkg::dmahf_wr_t wr_out,
  output logic take_out,
  output logic ack_out
);

  logic ack_ff;
  logic take;
  logic lane0;

  function automatic logic adr_is(input logic [`DMAHF_ADR_W-1:0] adr,
                                  input logic [`DMAHF_ADR_W-1:0] off);
    adr_is = (adr[`DMAHF_ADR_W-1:2] == off[`DMAHF_ADR_W-1:2]);
  endfunction : adr_is

  // Answer every access, mapped or not, one cycle after it starts
  assign take = req_in.cyc & req_in.stb & ~ack_ff;
  assign lane0 = req_in.sel[0];

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // Writes land at the ack edge
  always_comb begin
    wr_out = '0;
    wr_out.wdat = req_in.dat;
    if (ack_ff && req_in.we && lane0) begin
      wr_out.wr_page = adr_is(req_in.adr, `DMAHF_OFF_PAGE);
      wr_out.wr_flags = adr_is(req_in.adr, `DMAHF_OFF_FLAGS) & flag_page_ok_in; // see [RL7]
      wr_out.wr_config = adr_is(req_in.adr, `DMAHF_OFF_CONFIG);
      wr_out.wr_bitop = adr_is(req_in.adr, `DMAHF_OFF_BITOP) & flag_page_ok_in; // see [RL7]
    end
  end

  assign take_out = take;
  assign ack_out = ack_ff;

endmodule : dmahf_wb_slave

`default_nettype wire

// >>> rtl/dmahf_midpoint_top.sv
// Mid-point flag register and interrupt of a seven-channel DMA engine.
// Assumes the DMA engine supplies per-channel offset and size on mclk_in.
//
// Notes on behaviour
// [RL1] One flag per channel 0..6 at bits 0..6; 1 means mid-point reached.
// [RL2] Even size: flag sets when offset becomes equal to half the size.
// [RL3] Odd size: flag sets when offset equals half the size plus one.
// [RL4] Software clears a flag itself; hardware never clears it.
// [RL5] Interrupt raised only while the channel's mid-point enable is set.
// [RL6] Bit 7 reserved, reads zero; software writes zero there.
// [RL7] Flags respond on page 0xF at 0x88, with single-bit access.
// [RL8] Reset clears flags; written zero clears; hardware set wins.
`include "dmahf_map.svh"
`default_nettype none

module dmahf_midpoint_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [`DMAHF_ADR_W-1:0] wb_adr_in,
  input wire logic [`DMAHF_DAT_W-1:0] wb_dat_in,
  output logic [`DMAHF_DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // DMA engine progress
  input wire logic [`DMAHF_NUM_CHAN-1:0][`DMAHF_XFER_W-1:0] chan_transfer_offset_in,
  input wire logic [`DMAHF_NUM_CHAN-1:0][`DMAHF_XFER_W-1:0] chan_transfer_size_in,
  // Flags and interrupt
  output logic [`DMAHF_NUM_CHAN-1:0] dma_midpoint_flags_out,
  output logic half_irq_out
);

  // ==========================================================
  // Declarations
  dmahf_pkg::dmahf_wb_req_t req;
  dmahf_pkg::dmahf_wr_t wr;
  dmahf_pkg::dmahf_chan_vec_t hit;
  dmahf_pkg::dmahf_chan_vec_t flags_ff;
  dmahf_pkg::dmahf_chan_vec_t nxt_flags;
  dmahf_pkg::dmahf_chan_vec_t half_irq_enable_ff;
  dmahf_pkg::dmahf_chan_vec_t nxt_half_irq_enable;
  logic [2:0] chan_select_ff;
  logic [3:0] page_ff;
  logic flag_page_ok;
  logic take;
  logic irq_ff;
  logic [`DMAHF_DAT_W-1:0] rdat_ff;
  logic [`DMAHF_DAT_W-1:0] nxt_rdat;
  logic [2:0] bit_idx;
  logic bit_val;
  logic [2:0] cfg_sel;

  function automatic logic adr_is(input logic [`DMAHF_ADR_W-1:0] adr,
                                  input logic [`DMAHF_ADR_W-1:0] off);
    adr_is = (adr[`DMAHF_ADR_W-1:2] == off[`DMAHF_ADR_W-1:2]);
  endfunction : adr_is

  function automatic logic chan_ok(input logic [2:0] idx);
    chan_ok = (idx < 3'(`DMAHF_NUM_CHAN));
  endfunction : chan_ok

  // ==========================================================
  // Bus front end
  assign req.cyc = wb_cyc_in;
  assign req.stb = wb_stb_in;
  assign req.we = wb_we_in;
  assign req.sel = wb_sel_in;
  assign req.adr = wb_adr_in;
  assign req.dat = wb_dat_in;

  assign flag_page_ok = (page_ff == `DMAHF_FLAG_PAGE); // see [RL7]

  dmahf_wb_slave u_slave (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(req),
    .flag_page_ok_in(flag_page_ok),
    .wr_out(wr),
    .take_out(take),
    .ack_out(wb_ack_out)
  );

  // ==========================================================
  // Per-channel detectors
  genvar gi;
  generate
    for (gi = 0; gi < `DMAHF_NUM_CHAN; gi++) begin : g_chan
      dmahf_half_detect u_det (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .chan_transfer_offset_in(chan_transfer_offset_in[gi]),
        .chan_transfer_size_in(chan_transfer_size_in[gi]),
        .hit_out(hit[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Page select
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      page_ff <= `DMAHF_RST_PAGE;
    end else if (wr.wr_page) begin
      page_ff <= wr.wdat[`DMAHF_PAGE_MSB:`DMAHF_PAGE_LSB];
    end
  end

  // ==========================================================
  // Flag register
  assign bit_idx = wr.wdat[`DMAHF_BITOP_IDX_MSB:`DMAHF_BITOP_IDX_LSB];
  assign bit_val = wr.wdat[`DMAHF_BITOP_VAL_BIT];

  always_comb begin
    nxt_flags = flags_ff;
    if (wr.wr_flags) begin
      // Bit 7 has no storage, whatever is written there
      nxt_flags = wr.wdat[`DMAHF_NUM_CHAN-1:0]; // see [RL6] [RL8]
    end else if (wr.wr_bitop && chan_ok(bit_idx)) begin
      // Single-bit access avoids read-modify-write races with hardware
      nxt_flags[bit_idx] = bit_val; // see [RL7]
    end
    // A mid-point arriving with a clear is kept
    nxt_flags = nxt_flags | hit; // see [RL1] [RL8]
  end

  // Cleared only by software or reset, never by hardware
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      flags_ff <= `DMAHF_RST_FLAGS; // see [RL8]
    end else begin
      flags_ff <= nxt_flags; // see [RL4]
    end
  end

  // ==========================================================
  // Channel configuration: select and mid-point enables
  assign cfg_sel = wr.wdat[`DMAHF_CFG_SEL_MSB:`DMAHF_CFG_SEL_LSB];

  always_comb begin
    nxt_half_irq_enable = half_irq_enable_ff;
    if (wr.wr_config && chan_ok(cfg_sel)) begin
      nxt_half_irq_enable[cfg_sel] = wr.wdat[`DMAHF_CFG_EN_BIT]; // see [RL5]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      half_irq_enable_ff <= `DMAHF_RST_ENABLE;
      chan_select_ff <= `DMAHF_RST_SELECT;
    end else begin
      half_irq_enable_ff <= nxt_half_irq_enable;
      if (wr.wr_config) begin
        chan_select_ff <= cfg_sel;
      end
    end
  end

  // ==========================================================
  // Interrupt
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(flags_ff & half_irq_enable_ff); // see [RL5]
    end
  end

  assign half_irq_out = irq_ff;
  assign dma_midpoint_flags_out = flags_ff;

  // ==========================================================
  // Read data, captured when the access is taken
  always_comb begin
    nxt_rdat = '0;
    if (adr_is(wb_adr_in, `DMAHF_OFF_PAGE)) begin
      nxt_rdat[`DMAHF_PAGE_MSB:`DMAHF_PAGE_LSB] = page_ff;
    end else if (adr_is(wb_adr_in, `DMAHF_OFF_FLAGS) && flag_page_ok) begin
      // Reserved bit 7 and above read zero
      nxt_rdat[`DMAHF_NUM_CHAN-1:0] = flags_ff; // see [RL1] [RL6] [RL7]
    end else if (adr_is(wb_adr_in, `DMAHF_OFF_CONFIG)) begin
      nxt_rdat[`DMAHF_CFG_SEL_MSB:`DMAHF_CFG_SEL_LSB] = chan_select_ff;
      nxt_rdat[`DMAHF_CFG_EN_BIT] = chan_ok(chan_select_ff)
                                    & half_irq_enable_ff[chan_select_ff];
      nxt_rdat[`DMAHF_CFG_ENALL_LSB +: `DMAHF_NUM_CHAN] = half_irq_enable_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdat_ff <= '0;
    end else if (take) begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_dat_out = rdat_ff;

endmodule : dmahf_midpoint_top

`default_nettype wire

// >>> tb/dmahf_midpoint_asserts.sv
// Checker of the mid-point flag block, bound to its top module.
// Assumes one clock domain and the top module's port names.
`include "dmahf_map.svh"
`default_nettype none

module dmahf_midpoint_asserts (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [`DMAHF_ADR_W-1:0] wb_adr_in,
  input wire logic [`DMAHF_DAT_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Progress, flags, interrupt
  input wire logic [`DMAHF_NUM_CHAN-1:0][`DMAHF_XFER_W-1:0] chan_transfer_offset_in,
  input wire logic [`DMAHF_NUM_CHAN-1:0][`DMAHF_XFER_W-1:0] chan_transfer_size_in,
  input wire logic [`DMAHF_NUM_CHAN-1:0] dma_midpoint_flags_out,
  input wire logic half_irq_out
);
  // ==========
  // Match history, cleared by reset so a match at release counts as new
  logic [6:0] match_vec;
  logic [6:0] prev_match_ff;
  logic [6:0] rise_vec;
  always_comb begin
    for (int i = 0; i < `DMAHF_NUM_CHAN; i++) begin
      match_vec[i] = chan_transfer_size_in[i] != 16'h0 && chan_transfer_offset_in[i] ==
        (chan_transfer_size_in[i] >> 1) + 16'(chan_transfer_size_in[i][0]);
    end
  end
  always_ff @(posedge mclk_in) begin
    prev_match_ff <= sys_rst_in ? 7'h00 : match_vec;
  end
  assign rise_vec = match_vec & ~prev_match_ff;
  // ==========
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  a_ack_timing: assert property (s_taken |=> s_ack_pulse)
    else $error("ack not one pulse after request");
  a_ack_cause: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_rsvd_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in[7:2] == 6'h22
    |-> wb_dat_out[31:7] == 25'h0) else $error("reserved flag bits not zero");
  a_flags_reset: assert property ($past(sys_rst_in) |-> dma_midpoint_flags_out == 7'h00)
    else $error("flags not cleared by reset");
  a_flag_sticky: assert property (|($past(dma_midpoint_flags_out) & ~dma_midpoint_flags_out)
    |-> $past(wb_ack_out && wb_we_in) || $past(sys_rst_in)) else $error("flag cleared alone");
  a_rise_cause: assert property (|(dma_midpoint_flags_out & ~$past(dma_midpoint_flags_out)
    & ~$past(rise_vec)) |-> $past(wb_ack_out && wb_we_in)) else $error("flag set off mid-point");
  a_set_on_match: assert property (|rise_vec
    |=> (dma_midpoint_flags_out & $past(rise_vec)) == $past(rise_vec))
    else $error("flag missed at mid-point");
  a_irq_gated: assert property (half_irq_out |-> $past(dma_midpoint_flags_out) != 7'h00)
    else $error("interrupt without flag");
endmodule : dmahf_midpoint_asserts

bind dmahf_midpoint_top dmahf_midpoint_asserts u_dmahf_midpoint_asserts (.mclk_in, .sys_rst_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out,
  .chan_transfer_offset_in, .chan_transfer_size_in, .dma_midpoint_flags_out, .half_irq_out);

`default_nettype wire

// >>> tb/dmahf_midpoint_top_tb_top.sv
// Bench of the mid-point flag block: bus tasks, channel sweep, irq gating.
// Assumes design, package and checker compiled before it.
`include "dmahf_map.svh"
`default_nettype none

module dmahf_midpoint_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Stimulus and results
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack_o;
  logic irq_o;
  logic [6:0] flg_o;
  logic [6:0][15:0] off = 112'h0;
  // Even, odd, smallest and widest sizes, channel 0 last
  logic [6:0][15:0] sz = {16'h0001, 16'hffff, 16'h0100, 16'h0003, 16'h0002, 16'h0007, 16'h0008};
  int n_errors = 0;
  int compares = 0;

  always #25 mclk_in = ~mclk_in;

  dmahf_midpoint_top u_dmahf_midpoint_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_sel_in(sel), .wb_adr_in(adr),
    .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack_o),
    .chan_transfer_offset_in(off), .chan_transfer_size_in(sz),
    .dma_midpoint_flags_out(flg_o), .half_irq_out(irq_o));

  // ==========
  // Bus and compare tasks
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Waits as long as ack takes; only the watchdog ends a hang
    do begin
      @(posedge mclk_in);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0, 4'hf);
    compares++;
    if (rdat !== exp) begin
      n_errors++;
      $display("unexpected read at %0t: %h got %h exp %h", $time, a, rdat, exp);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected pins at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wrap_up();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ==========
  // Watchdog, well beyond the sequence length
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_errors++;
    wrap_up();
  end

  // ==========
  // Tests
  initial begin
    logic [15:0] mid;
    logic [6:0] exp;
    exp = 7'h00;
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    chk_pin(flg_o, 7'h00);
    chk_rd(8'h88, 32'h0);
    wb_xfer(1'b1, 8'h84, 32'hf, 4'hf);
    chk_rd(8'h88, 32'h0);
    for (int c = 0; c < 7; c++) begin
      // One short of the mid-point is the rounded-down half for odd sizes
      mid = (sz[c] >> 1) + 16'(sz[c][0]);
      off[c] <= mid - 16'h1;
      repeat (3) @(posedge mclk_in);
      chk_pin(flg_o, exp);
      off[c] <= mid;
      repeat (3) @(posedge mclk_in);
      exp[c] = 1'b1;
      chk_pin(flg_o, exp);
    end
    chk_rd(8'h88, 32'h7f);
    off <= 112'h0;
    repeat (3) @(posedge mclk_in);
    chk_rd(8'h88, 32'h7f);
    wb_xfer(1'b1, 8'h88, 32'h0, 4'he);
    chk_rd(8'h88, 32'h7f);
    wb_xfer(1'b1, 8'h88, 32'h7e, 4'hf);
    chk_rd(8'h88, 32'h7e);
    wb_xfer(1'b1, 8'h90, 32'h1, 4'hf);
    chk_rd(8'h88, 32'h7c);
    chk_pin({6'h0, irq_o}, 7'h0);
    wb_xfer(1'b1, 8'h8c, 32'ha, 4'hf);
    repeat (2) @(posedge mclk_in);
    chk_pin({6'h0, irq_o}, 7'h1);
    chk_rd(8'h8c, 32'h040a);
    wb_xfer(1'b1, 8'h90, 32'h2, 4'hf);
    repeat (2) @(posedge mclk_in);
    chk_pin({6'h0, irq_o}, 7'h0);
    // Clear all flags at the very edge on which channel 0 reaches its mid-point
    mid = sz[0] >> 1;
    fork
      wb_xfer(1'b1, 8'h88, 32'h0, 4'hf);
      begin
        repeat (2) @(posedge mclk_in);
        off[0] <= mid;
      end
    join
    chk_rd(8'h88, 32'h01);
    wb_xfer(1'b1, 8'h90, 32'hd, 4'hf);
    chk_rd(8'h88, 32'h21);
    // Select 7 names no channel: stored, but no enable changes
    wb_xfer(1'b1, 8'h8c, 32'hf, 4'hf);
    chk_rd(8'h8c, 32'h0407);
    // Mid-run reset; channel 0 still sits at its mid-point and sets again
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk_pin(flg_o, 7'h01);
    wb_xfer(1'b1, 8'h84, 32'h0, 4'hf);
    chk_rd(8'h88, 32'h0);
    chk_rd(8'ha0, 32'h0);
    wrap_up();
  end
endmodule : dmahf_midpoint_top_tb_top

`default_nettype wire
